// ### pkg/limit_pkg.sv
/*
 Shared constants and carriers for the limit test and binning block.
 Assumes a 25 MHz pclk and an APB master with 32-bit data.
*/
package limit_pkg;
	localparam int CLK_HZ = 25000000;
	// Strobe must exceed 10 us: one extra cycle keeps it strictly longer
	localparam int STROBE_US = 10;
	localparam int STROBE_CYC = (STROBE_US * (CLK_HZ / 1000000)) + 1;
	localparam int STROBE_W = 9;
	localparam logic [STROBE_W-1:0] STROBE_LEN = STROBE_CYC[STROBE_W-1:0];

	localparam int RD_W = 32;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACTION = 8'h04;
	localparam logic [7:0] ADDR_PATTERN = 8'h08;
	localparam logic [7:0] ADDR_LO1 = 8'h0c;
	localparam logic [7:0] ADDR_HI1 = 8'h10;
	localparam logic [7:0] ADDR_LO2 = 8'h14;
	localparam logic [7:0] ADDR_HI2 = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_READING = 8'h20;
	localparam logic [7:0] ADDR_DIRECT = 8'h24;

	// CTRL fields
	localparam int CTRL_EN1 = 0;
	localparam int CTRL_EN2 = 1;
	localparam int CTRL_AUTO1 = 2;
	localparam int CTRL_AUTO2 = 3;
	localparam int CTRL_STROBE = 4;
	localparam int CTRL_POL_LSB = 8;
	// ACTION fields (write one to act)
	localparam int ACT_CLR1 = 0;
	localparam int ACT_CLR2 = 1;
	localparam int ACT_REEVAL = 2;
	// PATTERN fields: pass, lo1, hi1, lo2, hi2 nibbles
	localparam int PAT_PASS = 0;
	localparam int PAT_LO1 = 4;
	localparam int PAT_HI1 = 8;
	localparam int PAT_LO2 = 12;
	localparam int PAT_HI2 = 16;
	// STATUS fields
	localparam int ST_FAIL1 = 0;
	localparam int ST_FAIL2 = 1;
	localparam int ST_COMP = 2;
	localparam int ST_LINES = 4;

	localparam logic [3:0] PAT_RST = 4'h0;
	localparam logic [3:0] POL_RST = 4'hf;

	typedef struct packed {
		logic signed [RD_W-1:0] lo1;
		logic signed [RD_W-1:0] hi1;
		logic signed [RD_W-1:0] lo2;
		logic signed [RD_W-1:0] hi2;
	} limits_t;

	typedef struct packed {
		logic [3:0] pass;
		logic [3:0] lo1;
		logic [3:0] hi1;
		logic [3:0] lo2;
		logic [3:0] hi2;
	} patterns_t;

	typedef struct packed {
		logic fail1;
		logic fail2;
		logic [3:0] pattern;
	} verdict_t;
endpackage

// ### src/bin_strobe.sv
/*
 Strobe pulse generator for line four of the output port.
 Assumes start is a one-cycle pulse on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module bin_strobe (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	output logic active
);
	import limit_pkg::*;

	logic [STROBE_W-1:0] count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (start) begin
			count <= STROBE_LEN;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign active = (count != '0);
endmodule
`default_nettype wire

// ### src/limit_eval.sv
/*
 Combinational evaluation of one reading against both limit pairs.
 Assumes limits and patterns are stable while the result is sampled.
*/
`timescale 1ns/100ps
`default_nettype none
module limit_eval (
	// Inputs
	input wire logic signed [limit_pkg::RD_W-1:0] reading,
	input wire logic en1,
	input wire logic en2,
	input wire limit_pkg::limits_t lim,
	input wire limit_pkg::patterns_t pat,
	// Result
	output limit_pkg::verdict_t verdict
);
	import limit_pkg::*;

	logic lo1_bad, hi1_bad, lo2_bad, hi2_bad;

	// Disabled pairs report no outcome at all
	assign lo1_bad = en1 && (reading < lim.lo1);
	assign hi1_bad = en1 && (reading > lim.hi1);
	assign lo2_bad = en2 && (reading < lim.lo2);
	assign hi2_bad = en2 && (reading > lim.hi2);

	always_comb begin
		verdict.fail1 = lo1_bad | hi1_bad;
		verdict.fail2 = lo2_bad | hi2_bad;
		// Priority chain follows the test order; first failure wins
		if (lo1_bad) begin
			verdict.pattern = pat.lo1;
		end else if (hi1_bad) begin
			verdict.pattern = pat.hi1;
		end else if (lo2_bad) begin
			verdict.pattern = pat.lo2;
		end else if (hi2_bad) begin
			verdict.pattern = pat.hi2;
		end else begin
			verdict.pattern = pat.pass;
		end
	end
endmodule
`default_nettype wire

// ### src/limit_test_binning.sv
/*
 Limit test and binning: APB registers, sticky fail flags, output port.
 Assumes an APB master on pclk and a measurement core that pulses
 reading_valid with each new reading and pulses idle_enter on idle entry.
*/
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Each enabled pair is checked against every new reading.
// - Order: low one, high one, low two, high two.
// - Disabled pairs are skipped and give no outcome.
// - Any enabled pair takes the port; direct writes are ignored.
// - Disabling a pair clears its sticky fail flag.
// - Fail flag reads 1 on fail, 0 on pass, no bound shown.
// - Reading a fail flag leaves it unchanged.
// - Clear action resets that pair's flag at once.
// - Auto-clear resets flag on idle entry; otherwise it holds.
// - No failure drives the programmed pass pattern.
// - Pattern bit n drives line n+1, weight two to the n.
// - Each line's true level follows its own polarity bit.
// - With strobe on, line four leaves the pattern.
// - With strobe on, pattern first, then over 10 us pulse on line four.
// - Composite result is OR of both fail flags.
// - Reading the composite result clears nothing.
// - New limits and patterns apply from the next evaluation; polarity and strobe settings apply at once.
// - Without a new conversion or a re-evaluate no test runs.
// - Re-evaluate reruns tests on the stored reading, current limits.
// - Re-evaluate never starts a conversion.
// - Each bound has its own fail pattern.
// - First failing bound in a pass picks the pattern.
module limit_test_binning (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurement core
	input wire logic reading_valid,
	input wire logic [limit_pkg::RD_W-1:0] reading_in,
	input wire logic idle_enter,
	// Digital output port
	output logic [3:0] dout
);
	import limit_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic en1, en2, auto1, auto2, strobe_en;
	logic [3:0] polarity;
	patterns_t pat;
	limits_t lim;
	logic [3:0] direct;
	logic [RD_W-1:0] last_reading;
	logic fail1, fail2;
	logic [3:0] lines_true;
	logic strobe_start;

	logic wr_en, rd_en;
	logic clr1, clr2, reeval;
	logic eval_now;
	logic limit_owns;
	verdict_t verdict;
	logic strobe_active;

	// Zero wait states: every access completes in its first access cycle
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	assign clr1 = wr_en && (paddr == ADDR_ACTION) && pwdata[ACT_CLR1];
	assign clr2 = wr_en && (paddr == ADDR_ACTION) && pwdata[ACT_CLR2];
	assign reeval = wr_en && (paddr == ADDR_ACTION) && pwdata[ACT_REEVAL];

	// Only a completed conversion or an explicit re-run triggers a test
	assign eval_now = reading_valid || reeval;
	assign limit_owns = en1 || en2;

	// ------------------------------------------------------------
	// Configuration writes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en1 <= 1'b0;
			en2 <= 1'b0;
			auto1 <= 1'b0;
			auto2 <= 1'b0;
			strobe_en <= 1'b0;
			polarity <= POL_RST;
		end else if (wr_en && paddr == ADDR_CTRL) begin
			en1 <= pwdata[CTRL_EN1];
			en2 <= pwdata[CTRL_EN2];
			auto1 <= pwdata[CTRL_AUTO1];
			auto2 <= pwdata[CTRL_AUTO2];
			strobe_en <= pwdata[CTRL_STROBE];
			polarity <= pwdata[CTRL_POL_LSB +: 4];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat <= '{PAT_RST, PAT_RST, PAT_RST, PAT_RST, PAT_RST};
		end else if (wr_en && paddr == ADDR_PATTERN) begin
			pat.pass <= pwdata[PAT_PASS +: 4];
			pat.lo1 <= pwdata[PAT_LO1 +: 4];
			pat.hi1 <= pwdata[PAT_HI1 +: 4];
			pat.lo2 <= pwdata[PAT_LO2 +: 4];
			pat.hi2 <= pwdata[PAT_HI2 +: 4];
		end
	end

	// Limits change nothing until the next evaluation picks them up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim <= '0;
		end else if (wr_en) begin
			case (paddr)
			ADDR_LO1: lim.lo1 <= pwdata;
			ADDR_HI1: lim.hi1 <= pwdata;
			ADDR_LO2: lim.lo2 <= pwdata;
			ADDR_HI2: lim.hi2 <= pwdata;
			default: lim <= lim;
			endcase
		end
	end

	// General output control; ignored while a limit pair owns the port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direct <= 4'h0;
		end else if (wr_en && paddr == ADDR_DIRECT && !limit_owns) begin
			direct <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Reading store and evaluation
	// ------------------------------------------------------------
	// Re-evaluation reuses this store and never asks for a conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reading <= '0;
		end else if (reading_valid) begin
			last_reading <= reading_in;
		end
	end

	limit_eval u_eval (
		.reading(reading_valid ? reading_in : last_reading),
		.en1(en1),
		.en2(en2),
		.lim(lim),
		.pat(pat),
		.verdict(verdict)
	);

	// ------------------------------------------------------------
	// Sticky fail flags
	// ------------------------------------------------------------
	// A failing test wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail1 <= 1'b0;
		end else if (!en1) begin
			fail1 <= 1'b0;
		end else if (eval_now && verdict.fail1) begin
			fail1 <= 1'b1;
		end else if (clr1 || (auto1 && idle_enter)) begin
			fail1 <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail2 <= 1'b0;
		end else if (!en2) begin
			fail2 <= 1'b0;
		end else if (eval_now && verdict.fail2) begin
			fail2 <= 1'b1;
		end else if (clr2 || (auto2 && idle_enter)) begin
			fail2 <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output pattern and strobe
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_true <= 4'h0;
			strobe_start <= 1'b0;
		end else begin
			strobe_start <= eval_now && limit_owns && strobe_en;
			if (eval_now && limit_owns) begin
				lines_true <= verdict.pattern;
			end
		end
	end

	// Pulse starts the cycle after the pattern lands on lines one to three
	bin_strobe u_strobe (
		.pclk(pclk),
		.presetn(presetn),
		.start(strobe_start),
		.active(strobe_active)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= 4'h0;
		end else if (limit_owns) begin
			dout[2:0] <= lines_true[2:0] ^ ~polarity[2:0];
			if (strobe_en) begin
				dout[3] <= strobe_active ^ ~polarity[3];
			end else begin
				dout[3] <= lines_true[3] ^ ~polarity[3];
			end
		end else begin
			dout <= direct ^ ~polarity;
		end
	end

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	// Reads are side-effect free; flags keep their values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_en) begin
			prdata <= 32'h0;
			case (paddr)
			ADDR_CTRL: begin
				prdata[CTRL_EN1] <= en1;
				prdata[CTRL_EN2] <= en2;
				prdata[CTRL_AUTO1] <= auto1;
				prdata[CTRL_AUTO2] <= auto2;
				prdata[CTRL_STROBE] <= strobe_en;
				prdata[CTRL_POL_LSB +: 4] <= polarity;
			end
			ADDR_PATTERN: begin
				prdata[PAT_PASS +: 4] <= pat.pass;
				prdata[PAT_LO1 +: 4] <= pat.lo1;
				prdata[PAT_HI1 +: 4] <= pat.hi1;
				prdata[PAT_LO2 +: 4] <= pat.lo2;
				prdata[PAT_HI2 +: 4] <= pat.hi2;
			end
			ADDR_LO1: prdata <= lim.lo1;
			ADDR_HI1: prdata <= lim.hi1;
			ADDR_LO2: prdata <= lim.lo2;
			ADDR_HI2: prdata <= lim.hi2;
			ADDR_STATUS: begin
				prdata[ST_FAIL1] <= fail1;
				prdata[ST_FAIL2] <= fail2;
				prdata[ST_COMP] <= fail1 | fail2;
				prdata[ST_LINES +: 4] <= lines_true;
			end
			ADDR_READING: prdata <= last_reading;
			ADDR_DIRECT: prdata[3:0] <= direct;
			default: prdata <= 32'h0;
			endcase
		end
	end

	// Unmapped addresses answer with an error in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			case (paddr)
			ADDR_CTRL, ADDR_ACTION, ADDR_PATTERN, ADDR_LO1, ADDR_HI1,
			ADDR_LO2, ADDR_HI2, ADDR_STATUS, ADDR_READING,
			ADDR_DIRECT: pslverr <= 1'b0;
			default: pslverr <= 1'b1;
			endcase
		end else begin
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end
endmodule
`default_nettype wire

// ### tb/bin_handler.sv
/*
 Behavioural binning handler on the far side of the output port.
 Assumes active-high lines; line four is the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module bin_handler (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Output port
	input wire logic [3:0] lines,
	// Captured bin
	output logic [2:0] bin,
	output logic [7:0] bin_cnt
);
	logic prev;
	// Reads only after the strobe has stood one cycle, never at its edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bin <= 3'h0;
			bin_cnt <= 8'h00;
			prev <= 1'h0;
		end else begin
			prev <= lines[3];
			if (lines[3] && !prev)
				bin_cnt <= bin_cnt + 8'h01;
			if (lines[3] && prev)
				bin <= lines[2:0];
		end
	end
endmodule
`default_nettype wire

// ### tb/limit_binning_assertions.sv
/*
 Port-level checker for the limit test and binning block.
 Assumes polarity and strobe settings change only through APB writes.
*/
`timescale 1ns/100ps
`default_nettype none
module limit_binning_assertions (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Measurement and port
	input wire logic reading_valid,
	input wire logic [limit_pkg::RD_W-1:0] reading_in,
	input wire logic idle_enter,
	input wire logic [3:0] dout
);
	import limit_pkg::*;
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	logic wr;
	logic [11:0] ctrl;
	logic [2:0] cause;
	logic [8:0] hcnt;
	assign wr = psel & penable & pwrite & pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= 12'hf00;
		else if (wr && paddr == ADDR_CTRL)
			ctrl <= pwdata[11:0];
	end
	// Any change on lines one to three needs a reading, a write or idle entry behind it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cause <= 3'h0;
		else
			cause <= {cause[1:0], wr | reading_valid | idle_enter};
	end
	// Saturates so a stuck strobe cannot wrap back to a legal length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hcnt <= 9'h000;
		else if (dout[3])
			hcnt <= hcnt + {8'h00, hcnt != 9'h1ff};
		else
			hcnt <= 9'h000;
	end
	sequence strobe_rise;
		ctrl[4] && ctrl[11] && $rose(dout[3]);
	endsequence
	sequence strobe_end;
		ctrl[4] && ctrl[11] && $fell(dout[3]);
	endsequence
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	access_only_a: assert property (
		pready |-> psel && penable && $past(psel && !penable))
		else $error("ready outside access cycle");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (
		psel && !penable && paddr > ADDR_DIRECT |=> pslverr)
		else $error("unmapped access not refused");
	action_zero_a: assert property (
		pready && !pwrite && paddr == ADDR_ACTION |-> prdata == 32'h0)
		else $error("action register read not zero");
	composite_or_a: assert property (
		pready && !pwrite && paddr == ADDR_STATUS |->
		prdata[ST_COMP] == (prdata[ST_FAIL1] | prdata[ST_FAIL2]))
		else $error("composite is not the or of flags");
	port_cause_a: assert property ($changed(dout[2:0]) |-> |cause)
		else $error("output changed without cause");
	strobe_order_a: assert property (strobe_rise |-> $stable(dout[2:0]))
		else $error("strobe rose with pattern moving");
	strobe_len_a: assert property (strobe_end |-> hcnt > 9'd250)
		else $error("strobe too short");
endmodule
`default_nettype wire

// ### tb/limit_test_binning_test.sv
/*
 Self-checking bench for the limit test and binning block.
 Assumes the checker and the binning handler model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module limit_test_binning_test;
	import limit_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic reading_valid, idle_enter;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, reading_in, rd;
	logic [3:0] dout;
	logic [2:0] bin;
	logic [7:0] bin_cnt;
	int error_cnt, checks;
	logic [31:0] t_ctrl [8] = '{32'h0f03, 32'h0f03, 32'h0f03, 32'h0f03,
		32'h0f02, 32'h0f02, 32'h0f01, 32'h0e01};
	logic [31:0] t_rd [8] = '{32'h5, 32'hffffffec, 32'h32, 32'hc8,
		32'hfffffffb, 32'hc8, 32'ha, 32'h5};
	logic [3:0] t_out [8] = '{4'h6, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
	logic [2:0] t_st [8] = '{3'h0, 3'h7, 3'h5, 3'h7, 3'h6, 3'h6, 3'h0, 3'h0};

	always #20 pclk = ~pclk;

	limit_test_binning dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reading_valid(reading_valid), .reading_in(reading_in),
		.idle_enter(idle_enter), .dout(dout));
	bin_handler far (.pclk(pclk), .presetn(presetn), .lines(dout),
		.bin(bin), .bin_cnt(bin_cnt));

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		// No wait count assumed; only the watchdog ends a hung transfer
		while (pready !== 1'h1) begin
			@(posedge pclk);
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic st(input logic [2:0] e);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("status", {29'h0, e}, {29'h0, rd[2:0]});
	endtask
	task automatic port(input logic [3:0] e);
		repeat (4) @(posedge pclk);
		chk("dout", {28'h0, e}, {28'h0, dout});
	endtask
	// Line released after the pulse shows the inverse, not the old value
	task automatic meas(input logic [31:0] v);
		@(posedge pclk);
		reading_valid <= 1'h1;
		reading_in <= v;
		@(posedge pclk);
		reading_valid <= 1'h0;
		reading_in <= ~v;
		repeat (3) @(posedge pclk);
	endtask
	task automatic idle();
		@(posedge pclk);
		idle_enter <= 1'h1;
		@(posedge pclk);
		idle_enter <= 1'h0;
	endtask

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		{psel, penable, pwrite, reading_valid, idle_enter} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		reading_in = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h0f00, rd);
		apb(1'h0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, serr});
		apb(1'h1, ADDR_DIRECT, 32'h5);
		port(4'h5);
		apb(1'h1, ADDR_LO1, 32'hfffffff6);
		apb(1'h1, ADDR_HI1, 32'ha);
		apb(1'h1, ADDR_LO2, 32'h0);
		apb(1'h1, ADDR_HI2, 32'h64);
		apb(1'h1, ADDR_PATTERN, 32'h00043216);
		for (int i = 0; i < 8; i++) begin
			apb(1'h1, ADDR_ACTION, 32'h3);
			apb(1'h1, ADDR_CTRL, t_ctrl[i]);
			meas(t_rd[i]);
			apb(1'h1, ADDR_DIRECT, 32'h9);
			port(t_out[i]);
			repeat (2) st(t_st[i]);
		end
		apb(1'h1, ADDR_CTRL, 32'h0f03);
		meas(32'hffffffec);
		apb(1'h1, ADDR_ACTION, 32'h1);
		st(3'h6);
		idle();
		st(3'h6);
		apb(1'h1, ADDR_CTRL, 32'h0f0b);
		idle();
		st(3'h0);
		apb(1'h1, ADDR_CTRL, 32'h0f07);
		meas(32'hffffffec);
		idle();
		st(3'h6);
		meas(32'hffffffec);
		apb(1'h1, ADDR_CTRL, 32'h0f01);
		st(3'h5);
		apb(1'h1, ADDR_ACTION, 32'h1);
		meas(32'h5);
		apb(1'h1, ADDR_HI1, 32'h0);
		port(4'h6);
		apb(1'h1, ADDR_ACTION, 32'h4);
		port(4'h2);
		st(3'h5);
		apb(1'h0, ADDR_READING, 32'h0);
		chk("reading", 32'h5, rd);
		apb(1'h0, ADDR_DIRECT, 32'h0);
		chk("direct", 32'h5, rd);
		apb(1'h0, ADDR_ACTION, 32'h0);
		chk("action", 32'h0, rd);
		apb(1'h1, ADDR_PATTERN, 32'h0004321e);
		apb(1'h1, ADDR_CTRL, 32'h0f11);
		meas(32'hfffffffb);
		chk("strobe", 32'he, {28'h0, dout});
		repeat (300) @(posedge pclk);
		chk("after", 32'h6, {28'h0, dout});
		chk("bin", 32'h6, {29'h0, bin});
		chk("bins", 32'h1, {24'h0, bin_cnt});
		summarize();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
endmodule
bind limit_test_binning limit_binning_assertions chk_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .reading_valid(reading_valid),
	.reading_in(reading_in), .idle_enter(idle_enter), .dout(dout));
`default_nettype wire
